// ---- pkg/raddr_fifo_pkg.sv ----
// Purpose: Constants and types for the read address channel FIFO
// Assumes: Single clock, 16-word store, SECDED over the address word
// Notes:   Register offsets are byte addresses on the Avalon-MM port
package raddr_fifo_pkg;

    localparam int ADDR_W   = 32;
    localparam int PROT_W   = 4;
    localparam int DEPTH    = 16;
    localparam int PTR_W    = 4;
    localparam int LVL_W    = PTR_W + 1;
    localparam int THR_W    = PTR_W - 1;
    localparam int DATA_W   = ADDR_W + PROT_W;
    localparam int PAR_W    = 6;
    localparam int CW_W     = DATA_W + PAR_W + 1;
    localparam int EV_W     = 4;

    // Event bit positions, shared by status, enable and clear
    localparam int EV_WR_REFUSED = 0;
    localparam int EV_RD_REFUSED = 1;
    localparam int EV_SINGLE     = 2;
    localparam int EV_DOUBLE     = 3;

    // Codeword positions flipped by injection
    localparam int INJ_POS_A = 3;
    localparam int INJ_POS_B = 5;

    localparam logic [4:0] REG_CTRL    = 5'h00;
    localparam logic [4:0] REG_STATUS  = 5'h04;
    localparam logic [4:0] REG_IRQ_EN  = 5'h08;
    localparam logic [4:0] REG_IRQ_CLR = 5'h0C;
    localparam logic [4:0] REG_LEVEL   = 5'h10;

    localparam int CTRL_ECC_EN_BIT = 0;
    localparam int LEVEL_FULL_LSB  = 8;
    localparam int LEVEL_EMPTY_LSB = 16;

    localparam logic            RST_ECC_EN  = 1'b1;
    localparam logic [EV_W-1:0] RST_IRQ_EN  = 4'h0;
    localparam logic            RST_AEMPTY  = 1'b1;
    localparam logic            RST_WAITREQ = 1'b1;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [PROT_W-1:0] prot;
    } ar_payload_type;

    typedef struct packed {
        ar_payload_type payload;
        logic           single;
        logic           double;
    } ecc_result_type;

endpackage

// ---- verilog/raddr_fifo.sv ----
// Purpose: Read address channel FIFO with ECC, levels and flags
// Assumes: One clock; threshold inputs only change while rst is high
// Notes:   Registers over Avalon-MM, one wait state on every access
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: With ECC on, an injected single error flips one stored codeword bit.
// RULE2: With ECC on, an injected double error flips two stored codeword bits.
// RULE3: The single error flag marks a word whose one-bit error was corrected.
// RULE4: The double error flag marks a word with an uncorrectable two-bit error.
// RULE5: A write refused while full raises the write refused flag next cycle, storage intact.
// RULE6: Writes are held off while full; the flag still rises for each cycle valid is held high against that.
// RULE7: The write-side level never under-reports the words held and is five bits.
// RULE8: A write shows in the write-side level only from the following edge.
// RULE9: A read refused while empty raises the read refused flag next cycle, storage intact.
// RULE10: Reads are held off while empty; the flag still rises for each cycle ready is high on an empty FIFO.
// RULE11: The read-side level never over-reports readable words and is five bits.
// RULE12: A read shows in the read-side level only from the following edge.
// RULE13: A single five-bit level reports the words stored.
// RULE14: Almost full is high while the level is at or above the full threshold.
// RULE15: Almost empty is high while the level is at or below the empty threshold.
// RULE16: The thresholds are three bits and change only while the FIFO is in reset.
// RULE17: Injection is sampled with the accepted write; error flags travel with the word.
module raddr_fifo
    import raddr_fifo_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Upstream read address channel
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [PROT_W-1:0] s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // Downstream read address channel
    output logic      [ADDR_W-1:0] m_axi_araddr,
    output logic      [PROT_W-1:0] m_axi_arprot,
    output logic                   m_axi_arvalid,
    input  wire logic              m_axi_arready,
    // Error injection, taken only with an accepted write
    input  wire logic              raddr_inject_single_err,
    input  wire logic              raddr_inject_double_err,
    output logic                   raddr_single_err_flag,
    output logic                   raddr_double_err_flag,
    // Refusal flags, one cycle per refused attempt
    output logic                   raddr_write_refused_flag,
    output logic                   raddr_read_refused_flag,
    // Occupancy, store plus output stage
    output logic      [LVL_W-1:0]  raddr_write_side_level,
    output logic      [LVL_W-1:0]  raddr_read_side_level,
    output logic      [LVL_W-1:0]  raddr_common_level,
    output logic                   raddr_almost_full_flag,
    output logic                   raddr_almost_empty_flag,
    // Thresholds, not re-read safely outside reset
    input  wire logic [THR_W-1:0]  raddr_full_threshold,
    input  wire logic [THR_W-1:0]  raddr_empty_threshold,
    // Register bus
    input  wire logic [4:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [3:0]        avs_byteenable,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    output logic                   irq
);

    typedef struct packed {
        // Store and occupancy
        logic [DEPTH-1:0][CW_W-1:0] mem;
        logic [PTR_W-1:0]           wr_ptr;
        logic [PTR_W-1:0]           rd_ptr;
        logic [LVL_W-1:0]           mem_cnt;
        logic [LVL_W-1:0]           level;
        logic                       s_ready;
        // Output stage and the flags of its word
        ar_payload_type             m_payload;
        logic                       m_valid;
        logic                       single;
        logic                       double;
        // Status flags
        logic                       wr_refused;
        logic                       rd_refused;
        logic                       afull;
        logic                       aempty;
        // Register bank
        logic                       ecc_en;
        logic [EV_W-1:0]            ev_status;
        logic [EV_W-1:0]            ev_enable;
        logic                       irq;
        logic                       waitreq;
        logic [31:0]                rdata;
    } state_type;

    state_type state_q;
    state_type state_d;

    ////////////////////////////////////////////////////////////////////////////
    // SECDED: Hamming positions 1..42, overall parity in bit 0

    function automatic logic [CW_W-1:0] ecc_encode(input ar_payload_type din);
        logic [CW_W-1:0]   cw;
        logic [DATA_W-1:0] raw;
        logic [PAR_W-1:0]  syn;
        int                j;
        cw  = '0;
        raw = din;
        syn = '0;
        j   = 0;
        for (int p = 1; p < CW_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                cw[p] = raw[j];
                j++;
            end
        end
        for (int p = 1; p < CW_W; p++) begin
            if (cw[p]) begin
                syn = syn ^ PAR_W'(p);
            end
        end
        for (int i = 0; i < PAR_W; i++) begin
            cw[1 << i] = syn[i];
        end
        cw[0] = ^cw[CW_W-1:1];
        return cw;
    endfunction

    function automatic ecc_result_type ecc_decode(input logic [CW_W-1:0] cw_in,
                                                  input logic            ecc_on);
        logic [CW_W-1:0]   cw;
        logic [DATA_W-1:0] raw;
        logic [PAR_W-1:0]  syn;
        logic              par;
        ecc_result_type    res;
        int                j;
        cw  = cw_in;
        raw = '0;
        syn = '0;
        par = ^cw_in;
        res = '0;
        j   = 0;
        for (int p = 1; p < CW_W; p++) begin
            if (cw[p]) begin
                syn = syn ^ PAR_W'(p);
            end
        end
        // ECC off: flags stay low and the stored bits pass as they are
        if (ecc_on) begin
            if (par) begin
                // Odd parity: one flipped bit, syndrome points at it
                res.single = 1'b1; // RULE3
                if (syn != '0 && int'(syn) < CW_W) begin
                    cw[syn] = ~cw[syn];
                end
            end else if (syn != '0) begin
                res.double = 1'b1; // RULE4
            end
        end
        for (int p = 1; p < CW_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                raw[j] = cw[p];
                j++;
            end
        end
        res.payload = raw;
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic              push;
        logic              pop;
        logic              out_free;
        logic              acc;
        logic [CW_W-1:0]   wcw;
        ecc_result_type    dec;
        ar_payload_type    win;
        logic [EV_W-1:0]   ev_set;
        logic [LVL_W-1:0]  full_thr;
        logic [LVL_W-1:0]  empty_thr;
        logic [31:0]       rd;
        push      = 1'b0;
        pop       = 1'b0;
        out_free  = 1'b0;
        acc       = 1'b0;
        wcw       = '0;
        dec       = '0;
        win       = '0;
        ev_set    = '0;
        full_thr  = '0;
        empty_thr = '0;
        rd        = '0;
        state_d   = state_q;

        ////////////////////////////////////////////////////////////////////////
        // Read side

        // Output stage drains on the downstream handshake
        if (state_q.m_valid && m_axi_arready) begin
            state_d.m_valid = 1'b0;
            state_d.single  = 1'b0; // RULE17
            state_d.double  = 1'b0; // RULE17
        end

        // Only fetch when the stage is free and the store count is nonzero, so reads never meet an empty store
        out_free = !state_q.m_valid || m_axi_arready;
        pop      = (state_q.mem_cnt != '0) && out_free; // RULE10
        if (pop) begin
            dec               = ecc_decode(state_q.mem[state_q.rd_ptr], state_q.ecc_en);
            state_d.m_payload = dec.payload;
            state_d.m_valid   = 1'b1;
            state_d.single    = dec.single; // RULE3 RULE17
            state_d.double    = dec.double; // RULE4 RULE17
            state_d.rd_ptr    = state_q.rd_ptr + 1'b1;
            ev_set[EV_SINGLE] = dec.single;
            ev_set[EV_DOUBLE] = dec.double;
        end

        ////////////////////////////////////////////////////////////////////////
        // Write side

        // Ready already excludes a full store, so no write can overrun it
        push = s_axi_arvalid && state_q.s_ready; // RULE6
        if (push) begin
            win.addr = s_axi_araddr;
            win.prot = s_axi_arprot;
            wcw      = ecc_encode(win);
            if (state_q.ecc_en && raddr_inject_double_err) begin
                wcw[INJ_POS_A] = ~wcw[INJ_POS_A]; // RULE2 RULE17
                wcw[INJ_POS_B] = ~wcw[INJ_POS_B]; // RULE2
            end else if (state_q.ecc_en && raddr_inject_single_err) begin
                wcw[INJ_POS_A] = ~wcw[INJ_POS_A]; // RULE1 RULE17
            end
            state_d.mem[state_q.wr_ptr] = wcw;
            state_d.wr_ptr              = state_q.wr_ptr + 1'b1;
        end

        ////////////////////////////////////////////////////////////////////////
        // Levels and flags

        // Push and pop in one cycle leave the count unchanged
        state_d.mem_cnt = state_q.mem_cnt + LVL_W'(push) - LVL_W'(pop);

        // Level counts the store plus the output stage, registered
        state_d.level   = state_d.mem_cnt + LVL_W'(state_d.m_valid); // RULE7 RULE11 RULE13
        state_d.s_ready = state_d.level < LVL_W'(DEPTH);

        full_thr      = LVL_W'(raddr_full_threshold); // RULE16
        empty_thr     = LVL_W'(raddr_empty_threshold); // RULE16
        state_d.afull  = state_d.level >= full_thr; // RULE14
        state_d.aempty = state_d.level <= empty_thr; // RULE15

        // Refused attempts leave pointers and storage untouched
        state_d.wr_refused = s_axi_arvalid && !state_q.s_ready; // RULE5
        state_d.rd_refused = m_axi_arready && !state_q.m_valid
                             && (state_q.mem_cnt == '0); // RULE9
        ev_set[EV_WR_REFUSED] = state_d.wr_refused;
        ev_set[EV_RD_REFUSED] = state_d.rd_refused;

        ////////////////////////////////////////////////////////////////////////
        // Register access: one wait state, then the answer edge

        acc             = (avs_read || avs_write) && state_q.waitreq;
        state_d.waitreq = !acc;
        if (avs_write && !state_q.waitreq && avs_byteenable[0]) begin
            case (avs_address)
                REG_CTRL: begin
                    state_d.ecc_en = avs_writedata[CTRL_ECC_EN_BIT];
                end
                REG_IRQ_EN: begin
                    state_d.ev_enable = avs_writedata[EV_W-1:0];
                end
                REG_IRQ_CLR: begin
                    state_d.ev_status = state_q.ev_status & ~avs_writedata[EV_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // New events win over a clear in the same cycle
        state_d.ev_status = state_d.ev_status | ev_set;
        state_d.irq       = |(state_d.ev_status & state_d.ev_enable);

        if (acc && avs_read) begin
            case (avs_address)
                REG_CTRL: begin
                    rd[CTRL_ECC_EN_BIT] = state_q.ecc_en;
                end
                REG_STATUS: begin
                    rd[EV_W-1:0] = state_q.ev_status;
                end
                REG_IRQ_EN: begin
                    rd[EV_W-1:0] = state_q.ev_enable;
                end
                REG_LEVEL: begin
                    rd[LVL_W-1:0]                         = state_q.level;
                    rd[LEVEL_FULL_LSB +: THR_W]           = raddr_full_threshold;
                    rd[LEVEL_EMPTY_LSB +: THR_W]          = raddr_empty_threshold;
                end
                default: begin
                    rd = '0;
                end
            endcase
            state_d.rdata = rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q           <= '0;
            state_q.ecc_en    <= RST_ECC_EN;
            state_q.ev_enable <= RST_IRQ_EN;
            state_q.aempty    <= RST_AEMPTY;
            state_q.waitreq   <= RST_WAITREQ;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register

    assign s_axi_arready            = state_q.s_ready;
    assign m_axi_araddr             = state_q.m_payload.addr;
    assign m_axi_arprot             = state_q.m_payload.prot;
    assign m_axi_arvalid            = state_q.m_valid;
    assign raddr_single_err_flag    = state_q.single;
    assign raddr_double_err_flag    = state_q.double;
    assign raddr_write_refused_flag = state_q.wr_refused;
    assign raddr_read_refused_flag  = state_q.rd_refused;
    // One clock: both sides see the same registered level
    assign raddr_write_side_level   = state_q.level; // RULE8
    assign raddr_read_side_level    = state_q.level; // RULE12
    assign raddr_common_level       = state_q.level;
    assign raddr_almost_full_flag   = state_q.afull;
    assign raddr_almost_empty_flag  = state_q.aempty;
    assign avs_readdata             = state_q.rdata;
    assign avs_waitrequest          = state_q.waitreq;
    assign irq                      = state_q.irq;

endmodule

// ---- dv/raddr_fifo_checker.sv ----
// Purpose: Port assertions for the read address FIFO
// Assumes: One clock; thresholds held still out of reset
// Notes:   Flag checks wait for a settled level since both are registered
`timescale 1ns/1ps
module raddr_fifo_checker
    import raddr_fifo_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [ADDR_W-1:0] m_axi_araddr,
    input wire logic              m_axi_arvalid,
    input wire logic              m_axi_arready,
    input wire logic              raddr_single_err_flag,
    input wire logic              raddr_double_err_flag,
    input wire logic              raddr_write_refused_flag,
    input wire logic              raddr_read_refused_flag,
    input wire logic [LVL_W-1:0]  raddr_write_side_level,
    input wire logic [LVL_W-1:0]  raddr_read_side_level,
    input wire logic [LVL_W-1:0]  raddr_common_level,
    input wire logic              raddr_almost_full_flag,
    input wire logic              raddr_almost_empty_flag,
    input wire logic [THR_W-1:0]  raddr_full_threshold,
    input wire logic [THR_W-1:0]  raddr_empty_threshold,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic              avs_waitrequest
);
    wire wr_take = s_axi_arvalid && s_axi_arready;
    wire rd_take = m_axi_arvalid && m_axi_arready;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    wr_refused_a: assert property (
        s_axi_arvalid && !s_axi_arready |=> raddr_write_refused_flag) else $error("no write refusal");
    rd_refused_a: assert property (
        m_axi_arready && !m_axi_arvalid && raddr_common_level == 5'h0
        |=> raddr_read_refused_flag) else $error("no read refusal");
    level_up_a: assert property (
        wr_take && !rd_take |=> raddr_common_level == $past(raddr_common_level) + 5'h1)
        else $error("level did not rise");
    level_down_a: assert property (
        rd_take && !wr_take |=> raddr_common_level == $past(raddr_common_level) - 5'h1)
        else $error("level did not fall");
    wr_level_a: assert property (
        raddr_write_side_level >= raddr_common_level && raddr_common_level <= 5'h10)
        else $error("write level low");
    rd_level_a: assert property (
        raddr_read_side_level <= raddr_common_level) else $error("read level high");
    rd_avail_a: assert property (
        raddr_read_side_level != 5'h0 |-> ##[0:1] m_axi_arvalid)
        else $error("level without word");
    wr_room_a: assert property (
        !$past(rst) && raddr_write_side_level < 5'h10 |-> s_axi_arready)
        else $error("room but not ready");
    almost_full_a: assert property (
        $stable(raddr_common_level) |-> raddr_almost_full_flag
        == (raddr_common_level >= {2'h0, raddr_full_threshold})) else $error("almost full");
    almost_empty_a: assert property (
        $stable(raddr_common_level) |-> raddr_almost_empty_flag
        == (raddr_common_level <= {2'h0, raddr_empty_threshold})) else $error("almost empty");
    err_valid_a: assert property (
        raddr_single_err_flag || raddr_double_err_flag |-> m_axi_arvalid)
        else $error("flag without word");
    out_hold_a: assert property (
        m_axi_arvalid && !m_axi_arready |=> m_axi_arvalid && $stable(m_axi_araddr)
        && $stable(raddr_single_err_flag) && $stable(raddr_double_err_flag))
        else $error("output word moved");
    wait_state_a: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("wait state wrong");
    cover property (raddr_almost_full_flag && !s_axi_arready);
    cover property (raddr_double_err_flag && m_axi_arready);
    cover property (raddr_read_refused_flag);
endmodule

bind raddr_fifo raddr_fifo_checker chk_i (.*);

// ---- dv/raddr_sink_model.sv ----
// Purpose: Downstream read address slave that drains the FIFO
// Assumes: Ready may be given without waiting for valid
// Notes:   Slow mode stalls on a pseudo random pattern
`timescale 1ns/1ps
module raddr_sink_model (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic hold,
    input  wire logic slow,
    output logic      m_axi_arready
);
    logic [7:0] lfsr_q;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lfsr_q        <= 8'h5a;
            m_axi_arready <= 1'b0;
        end else begin
            lfsr_q        <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
            m_axi_arready <= !hold && (!slow || lfsr_q[0]);
        end
    end
endmodule

// ---- dv/tb_axil_read_addr_fifo_status.sv ----
// Purpose: Self-checking bench for the read address FIFO status block
// Assumes: Thresholds set before reset ends; sink model drains
// Notes:   Payload of a double error word is corrupt and not compared
`timescale 1ns/1ps
module tb_axil_read_addr_fifo_status
    import raddr_fifo_pkg::*;
;
    logic clk_sys = 1'b0, rst = 1'b1, hold = 1'b1, slow = 1'b0, ecc_en = 1'b1;
    logic [ADDR_W-1:0] s_axi_araddr = '0, m_axi_araddr;
    logic [PROT_W-1:0] s_axi_arprot = '0, m_axi_arprot;
    logic s_axi_arvalid = 1'b0, raddr_inject_single_err = 1'b0, raddr_inject_double_err = 1'b0;
    logic s_axi_arready, m_axi_arvalid, m_axi_arready, raddr_single_err_flag;
    logic raddr_double_err_flag, raddr_write_refused_flag, raddr_read_refused_flag;
    logic raddr_almost_full_flag, raddr_almost_empty_flag, avs_waitrequest, irq;
    logic [LVL_W-1:0] raddr_write_side_level, raddr_read_side_level, raddr_common_level;
    logic [THR_W-1:0] raddr_full_threshold = 3'h6, raddr_empty_threshold = 3'h2;
    logic [4:0] avs_address = '0;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = '0, avs_readdata, rdata, seed = 32'h4bf3, r;
    int failures = 0, checked = 0;
    ecc_result_type q[$], mon_e;
    raddr_fifo dut (.*);
    raddr_sink_model sink (.*);
    always #2.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wrap_up();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wait_until(input int n);
        if (n >= 2000) begin
            failures++;
            wrap_up();
        end
    endtask
    // Request held until the edge that samples ready high
    task push(input logic si, input logic di);
        ecc_result_type e;
        int n;
        e.payload = DATA_W'({rnd(), rnd()});
        e.single = ecc_en & si & ~di;
        e.double = ecc_en & di;
        s_axi_araddr <= e.payload.addr;
        s_axi_arprot <= e.payload.prot;
        s_axi_arvalid <= 1'b1;
        raddr_inject_single_err <= si;
        raddr_inject_double_err <= di;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (s_axi_arready !== 1'b1 && n < 2000);
        wait_until(n);
        q.push_back(e);
    endtask
    task idle();
        s_axi_arvalid <= 1'b0;
        raddr_inject_single_err <= 1'b0;
        raddr_inject_double_err <= 1'b0;
        @(posedge clk_sys);
    endtask
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= ~wr;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (avs_waitrequest !== 1'b0 && n < 2000);
        wait_until(n);
        rdata = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // Ends with the sink ready on an empty store, so a read refusal is logged
    task drain();
        int n;
        hold <= 1'b0;
        slow <= 1'b1;
        n = 0;
        do begin @(posedge clk_sys); n++; end while (raddr_common_level !== 5'h0 && n < 2000);
        wait_until(n);
        slow <= 1'b0;
        repeat (3) @(posedge clk_sys);
        hold <= 1'b1;
        chk("read refused", raddr_read_refused_flag, 1);
        chk("queue left", q.size(), 0);
        chk("almost empty", raddr_almost_empty_flag, 1);
    endtask
    always @(posedge clk_sys) begin
        if (!rst && m_axi_arvalid === 1'b1 && m_axi_arready === 1'b1) begin
            if (q.size() == 0) chk("extra word", 1, 0);
            else begin
                mon_e = q.pop_front();
                chk("single flag", raddr_single_err_flag, mon_e.single);
                chk("double flag", raddr_double_err_flag, mon_e.double);
                if (!mon_e.double) chk("payload", {m_axi_araddr, m_axi_arprot}, mon_e.payload);
            end
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("level", raddr_common_level, 0);
        chk("almost empty", raddr_almost_empty_flag, 1);
        bus(0, REG_CTRL, 0);
        chk("ctrl", rdata, 1);
        bus(0, REG_IRQ_EN, 0);
        chk("irq enable", rdata, 0);
        bus(0, 5'h14, 0);
        chk("unmapped", rdata, 0);
        avs_byteenable <= 4'he;
        bus(1, REG_IRQ_EN, 1);
        avs_byteenable <= 4'hf;
        bus(0, REG_IRQ_EN, 0);
        chk("byte 0 off", rdata, 0);
        bus(0, REG_LEVEL, 0);
        chk("level reg", rdata, 32'h0002_0600);
        bus(1, REG_IRQ_EN, 1);
        repeat (16) push(1'b0, 1'b0);
        // Valid stays up on a full store: refused attempts
        repeat (6) @(posedge clk_sys);
        chk("write level", raddr_write_side_level, 16);
        chk("read level", raddr_read_side_level, 16);
        chk("common level", raddr_common_level, 16);
        chk("not almost empty", raddr_almost_empty_flag, 0);
        chk("almost full", raddr_almost_full_flag, 1);
        chk("refused", raddr_write_refused_flag, 1);
        chk("irq", irq, 1);
        idle();
        bus(1, REG_IRQ_EN, 0);
        repeat (2) @(posedge clk_sys);
        chk("irq masked", irq, 0);
        bus(1, REG_IRQ_CLR, 1);
        bus(0, REG_STATUS, 0);
        chk("status", rdata, 0);
        drain();
        bus(0, REG_STATUS, 0);
        chk("status", rdata, 32'h0000_0002);
        bus(1, REG_IRQ_CLR, 32'h0000_000f);
        for (int i = 1; i >= 0; i--) begin
            ecc_en = i[0];
            bus(1, REG_CTRL, {31'h0, ecc_en});
            hold <= 1'b0;
            slow <= 1'b1;
            push(1'b1, 1'b0);
            push(1'b0, 1'b1);
            repeat (12) begin
                r = rnd();
                push(r[0], r[1]);
            end
            idle();
            drain();
            bus(0, REG_STATUS, 0);
            chk("ecc status", rdata, ecc_en ? 32'h0000_000e : 32'h0000_0002);
            bus(1, REG_IRQ_CLR, 32'h0000_000f);
        end
        wrap_up();
    end
endmodule
